/* File: clp_pkg.sv */
package clp_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLP_CLK_NS = 5;
    localparam int unsigned CLP_TICK_NS = 10_000_000;
    localparam int unsigned CLP_TICK_CYC = CLP_TICK_NS / CLP_CLK_NS;
    localparam int unsigned CLP_TICK_MS = 10;
    localparam int unsigned CLP_LONG_MS = 3000;
    localparam int unsigned CLP_LONG_TICKS = (CLP_LONG_MS + CLP_TICK_MS - 1) / CLP_TICK_MS;
    localparam int unsigned CLP_DEB_MS = 20;
    localparam int unsigned CLP_DEB_TICKS = (CLP_DEB_MS + CLP_TICK_MS - 1) / CLP_TICK_MS;

    // ------------------------------------------------------------
    // Parameter values
    // ------------------------------------------------------------
    localparam int unsigned CLP_PW = 14;
    localparam logic [13:0] CLP_TIME_MAX = 14'h2706;
    localparam logic [13:0] CLP_TIME_OFF = 14'h3FFF;
    localparam logic [13:0] CLP_FULL_SCALE = 14'h07D0;
    localparam logic [13:0] CLP_PARAM_RST = 14'h0000;
    localparam logic [13:0] CLP_STEP_0 = 14'h0001;
    localparam logic [13:0] CLP_STEP_1 = 14'h000A;
    localparam logic [13:0] CLP_STEP_2 = 14'h0064;
    localparam logic [1:0] CLP_CUR_MSD = 2'h2;

    // ------------------------------------------------------------
    // Keys and menu items
    // ------------------------------------------------------------
    localparam int unsigned CLP_NKEYS = 4;
    localparam int unsigned CLP_K_SET = 0;
    localparam int unsigned CLP_K_PLUS = 1;
    localparam int unsigned CLP_K_MINUS = 2;
    localparam int unsigned CLP_K_CANCEL = 3;
    localparam logic [3:0] CLP_ITEM_FIRST = 4'h1;
    localparam logic [3:0] CLP_ITEM_UPPER = 4'h1;
    localparam logic [3:0] CLP_ITEM_LOWER = 4'h2;
    localparam logic [3:0] CLP_ITEM_BLANK = 4'h3;
    localparam logic [3:0] CLP_ITEM_CONFIRM = 4'h4;
    localparam logic [3:0] CLP_ITEM_RELEASE = 4'h5;
    localparam logic [3:0] CLP_ITEM_LAST = 4'h9;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CLP_REG_CTRL = 8'h00;
    localparam logic [7:0] CLP_REG_STATUS = 8'h04;
    localparam logic [7:0] CLP_REG_UPPER = 8'h08;
    localparam logic [7:0] CLP_REG_LOWER = 8'h0C;
    localparam logic [7:0] CLP_REG_BLANK = 8'h10;
    localparam logic [7:0] CLP_REG_CONFIRM = 8'h14;
    localparam logic [7:0] CLP_REG_RELEASE = 8'h18;
    localparam logic [7:0] CLP_REG_CURRENT = 8'h1C;
    localparam int unsigned CLP_CTRL_MON_BIT = 0;
    localparam logic CLP_CTRL_MON_RST = 1'b1;
    localparam int unsigned CLP_ST_RELAY = 0;
    localparam int unsigned CLP_ST_VIOL = 1;
    localparam int unsigned CLP_ST_BLANK = 2;
    localparam int unsigned CLP_ST_LATCH = 3;
    localparam int unsigned CLP_ST_MENU = 4;
    localparam int unsigned CLP_ST_EDIT = 5;
    localparam int unsigned CLP_ST_ITEM = 8;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MENU_LIVE, MENU_SELECT, MENU_EDIT} clp_menu_type;
    typedef enum logic [2:0] {PROT_BLANK, PROT_IDLE, PROT_CONFIRM, PROT_TRIPPED, PROT_RELEASE} clp_prot_type;

endpackage : clp_pkg

/* File: clp_evt_if.sv */
`timescale 1ns/1ps
interface clp_evt_if;
    import clp_pkg::*;
    // Timebase tick and per-key events
    logic tick;
    logic [CLP_NKEYS-1:0] press;
    logic [CLP_NKEYS-1:0] rel_short;
    logic [CLP_NKEYS-1:0] rel_long;
    modport tick_src (output tick);
    modport key_src (input tick, output press, rel_short, rel_long);
    modport sink (input tick, press, rel_short, rel_long);
endinterface : clp_evt_if

/* File: clp_tick.sv */
`timescale 1ns/1ps
module clp_tick
    import clp_pkg::*;
#(
    parameter int unsigned TICK_DIV = CLP_TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    clp_evt_if.tick_src evt
);

    logic [31:0] cnt_q;
    logic tick_q;

    // Divider producing one pulse per 0.01 s
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 32'h00000000;
            tick_q <= 1'b0;
        end else if (cnt_q == 32'(TICK_DIV - 1)) begin
            cnt_q <= 32'h00000000;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h00000001;
            tick_q <= 1'b0;
        end
    end

    assign evt.tick = tick_q;

endmodule : clp_tick

/* File: clp_keys.sv */
`timescale 1ns/1ps
module clp_keys
    import clp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [CLP_NKEYS-1:0] key_n,
    clp_evt_if.key_src evt
);

    // ------------------------------------------------------------
    // Per-key synchroniser, debounce and press classifier
    // ------------------------------------------------------------
    for (genvar i = 0; i < CLP_NKEYS; i++) begin : g_key
        logic sync1_q;
        logic sync2_q;
        logic deb_q;
        logic [3:0] deb_cnt_q;
        logic [15:0] held_q;
        logic press_q;
        logic short_q;
        logic long_q;

        // Two-stage synchroniser, pressed level is high
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sync1_q <= 1'b0;
                sync2_q <= 1'b0;
            end else begin
                sync1_q <= ~key_n[i];
                sync2_q <= sync1_q;
            end
        end

        // Level must stay changed for the debounce time
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                deb_q <= 1'b0;
                deb_cnt_q <= 4'h0;
            end else if (sync2_q == deb_q) begin
                deb_cnt_q <= 4'h0;
            end else if (evt.tick) begin
                if (deb_cnt_q >= 4'(CLP_DEB_TICKS - 1)) begin
                    deb_q <= sync2_q;
                    deb_cnt_q <= 4'h0;
                end else begin
                    deb_cnt_q <= deb_cnt_q + 4'h1;
                end
            end
        end

        // Hold time and one-cycle events at press and release
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                held_q <= 16'h0000;
                press_q <= 1'b0;
                short_q <= 1'b0;
                long_q <= 1'b0;
            end else begin
                press_q <= 1'b0;
                short_q <= 1'b0;
                long_q <= 1'b0;
                if (sync2_q != deb_q && evt.tick && deb_cnt_q >= 4'(CLP_DEB_TICKS - 1)) begin
                    if (sync2_q) begin
                        press_q <= 1'b1;
                        held_q <= 16'h0000;
                    end else if (held_q >= 16'(CLP_LONG_TICKS)) begin
                        long_q <= 1'b1;
                    end else begin
                        short_q <= 1'b1;
                    end
                end else if (deb_q && evt.tick && held_q < 16'(CLP_LONG_TICKS)) begin
                    held_q <= held_q + 16'h0001;
                end
            end
        end

        assign evt.press[i] = press_q;
        assign evt.rel_short[i] = short_q;
        assign evt.rel_long[i] = long_q;
    end

endmodule : clp_keys

/* File: clp_protector.sv */
`timescale 1ns/1ps
module clp_protector
    import clp_pkg::*;
#(
    parameter int unsigned TICK_DIV = CLP_TICK_CYC,
    parameter logic [CLP_PW-1:0] FULL_SCALE = CLP_FULL_SCALE
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic key_set_n,
    input wire logic key_plus_n,
    input wire logic key_minus_n,
    input wire logic cancel_key_n,
    input wire logic [CLP_PW-1:0] cur_value,
    input wire logic cur_valid,
    output logic relay_on,
    output logic menu_active,
    output logic edit_blink,
    output logic [3:0] menu_item,
    output logic [CLP_PW-1:0] disp_value
);

    // ------------------------------------------------------------
    // Timebase and keypad
    // ------------------------------------------------------------
    clp_evt_if evt ();

    clp_tick #(
        .TICK_DIV(TICK_DIV)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .evt(evt.tick_src)
    );

    clp_keys u_keys (
        .pclk(pclk),
        .presetn(presetn),
        .key_n({cancel_key_n, key_minus_n, key_plus_n, key_set_n}),
        .evt(evt.key_src)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    clp_menu_type menu_q;
    clp_prot_type prot_q;
    logic [3:0] item_q;
    logic [1:0] cursor_q;
    logic [CLP_PW-1:0] edit_q;
    logic [CLP_PW-1:0] param_q [0:4];
    logic [CLP_PW-1:0] cur_q;
    logic [CLP_PW-1:0] tmr_q;
    logic mon_en_q;
    logic relay_q;
    logic [CLP_PW-1:0] disp_q;
    logic [31:0] rdata_q;

    logic [CLP_PW-1:0] upper_p;
    logic [CLP_PW-1:0] lower_p;
    logic [CLP_PW-1:0] blank_p;
    logic [CLP_PW-1:0] confirm_p;
    logic [CLP_PW-1:0] release_p;
    logic latched;
    logic viol;
    logic restore;
    logic editable;
    logic is_time;
    logic is_rel;
    logic [CLP_PW-1:0] step;
    logic [CLP_PW-1:0] item_max;
    logic [CLP_PW:0] sum;
    logic [CLP_PW-1:0] plus_val;
    logic [CLP_PW-1:0] minus_val;
    logic save_ok;
    logic store;
    logic [2:0] pidx;

    assign upper_p = param_q[0];
    assign lower_p = param_q[1];
    assign blank_p = param_q[2];
    assign confirm_p = param_q[3];
    assign release_p = param_q[4];
    assign latched = (release_p == CLP_TIME_OFF);
    assign pidx = 3'(item_q - CLP_ITEM_FIRST);

    // ------------------------------------------------------------
    // Limit checking
    // ------------------------------------------------------------
    // Latest sampled current
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_q <= CLP_PARAM_RST;
        end else if (cur_valid) begin
            cur_q <= cur_value;
        end
    end

    // Violation of either enabled limit
    always_comb begin
        viol = 1'b0;
        if (mon_en_q) begin
            if (upper_p != CLP_PARAM_RST && cur_q > upper_p) begin
                viol = 1'b1;
            end
            if (lower_p != CLP_PARAM_RST && cur_q < lower_p) begin
                viol = 1'b1;
            end
        end
    end

    assign restore = evt.rel_long[CLP_K_CANCEL] && !viol;

    // ------------------------------------------------------------
    // Protection sequence
    // ------------------------------------------------------------
    // Blanking, confirmation and release timers share one counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prot_q <= PROT_BLANK;
            tmr_q <= CLP_PARAM_RST;
        end else begin
            case (prot_q)
                PROT_BLANK: begin
                    if (tmr_q >= blank_p) begin
                        prot_q <= PROT_IDLE;
                        tmr_q <= CLP_PARAM_RST;
                    end else if (evt.tick) begin
                        tmr_q <= tmr_q + 14'h0001;
                    end
                end
                PROT_IDLE: begin
                    tmr_q <= CLP_PARAM_RST;
                    if (viol) begin
                        prot_q <= PROT_CONFIRM;
                    end
                end
                PROT_CONFIRM: begin
                    if (!viol) begin
                        prot_q <= PROT_IDLE;
                        tmr_q <= CLP_PARAM_RST;
                    end else if (tmr_q >= confirm_p) begin
                        prot_q <= PROT_TRIPPED;
                        tmr_q <= CLP_PARAM_RST;
                    end else if (evt.tick) begin
                        tmr_q <= tmr_q + 14'h0001;
                    end
                end
                PROT_TRIPPED: begin
                    tmr_q <= CLP_PARAM_RST;
                    if (latched) begin
                        if (restore) begin
                            prot_q <= PROT_IDLE;
                        end
                    end else if (!viol) begin
                        prot_q <= PROT_RELEASE;
                    end
                end
                PROT_RELEASE: begin
                    if (latched || viol) begin
                        prot_q <= PROT_TRIPPED;
                        tmr_q <= CLP_PARAM_RST;
                    end else if (tmr_q >= release_p) begin
                        prot_q <= PROT_IDLE;
                        tmr_q <= CLP_PARAM_RST;
                    end else if (evt.tick) begin
                        tmr_q <= tmr_q + 14'h0001;
                    end
                end
                default: begin
                    prot_q <= PROT_IDLE;
                    tmr_q <= CLP_PARAM_RST;
                end
            endcase
        end
    end

    // Relay drive follows the tripped states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_q <= 1'b0;
        end else begin
            relay_q <= (prot_q == PROT_TRIPPED) || (prot_q == PROT_RELEASE);
        end
    end

    // ------------------------------------------------------------
    // Value editing
    // ------------------------------------------------------------
    always_comb begin
        editable = (item_q >= CLP_ITEM_UPPER) && (item_q <= CLP_ITEM_RELEASE);
        is_time = (item_q >= CLP_ITEM_BLANK) && (item_q <= CLP_ITEM_RELEASE);
        is_rel = (item_q == CLP_ITEM_RELEASE);
        case (cursor_q)
            2'h0: step = CLP_STEP_0;
            2'h1: step = CLP_STEP_1;
            default: step = CLP_STEP_2;
        endcase
        item_max = is_time ? CLP_TIME_MAX : FULL_SCALE;
        sum = {1'b0, edit_q} + {1'b0, step};
        if (is_rel && edit_q == CLP_TIME_OFF) begin
            plus_val = CLP_TIME_OFF;
            minus_val = CLP_TIME_MAX;
        end else begin
            if (sum > {1'b0, item_max}) begin
                plus_val = (is_rel && cursor_q == CLP_CUR_MSD) ? CLP_TIME_OFF : item_max;
            end else begin
                plus_val = sum[CLP_PW-1:0];
            end
            minus_val = (edit_q < step) ? CLP_PARAM_RST : edit_q - step;
        end
        save_ok = 1'b1;
        if (item_q == CLP_ITEM_UPPER && edit_q != CLP_PARAM_RST) begin
            save_ok = (edit_q <= FULL_SCALE) &&
                      ((lower_p == CLP_PARAM_RST) ? (edit_q >= CLP_STEP_0) : (edit_q >= lower_p));
        end
        if (item_q == CLP_ITEM_LOWER && edit_q != CLP_PARAM_RST) begin
            save_ok = (upper_p == CLP_PARAM_RST) ? (edit_q <= FULL_SCALE) : (edit_q <= upper_p);
        end
        store = (menu_q == MENU_EDIT) && evt.rel_long[CLP_K_SET] && save_ok && editable;
    end

    // ------------------------------------------------------------
    // Menu navigation
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            menu_q <= MENU_LIVE;
            item_q <= CLP_ITEM_FIRST;
            cursor_q <= 2'h0;
            edit_q <= CLP_PARAM_RST;
        end else begin
            case (menu_q)
                MENU_LIVE: begin
                    if (evt.rel_long[CLP_K_SET]) begin
                        menu_q <= MENU_SELECT;
                        item_q <= CLP_ITEM_FIRST;
                    end
                end
                MENU_SELECT: begin
                    if (evt.press[CLP_K_PLUS]) begin
                        item_q <= (item_q == CLP_ITEM_LAST) ? CLP_ITEM_FIRST : item_q + 4'h1;
                    end else if (evt.press[CLP_K_MINUS]) begin
                        item_q <= (item_q == CLP_ITEM_FIRST) ? CLP_ITEM_LAST : item_q - 4'h1;
                    end else if (evt.rel_short[CLP_K_SET] && editable) begin
                        menu_q <= MENU_EDIT;
                        edit_q <= param_q[pidx];
                        cursor_q <= 2'h0;
                    end else if (evt.rel_short[CLP_K_CANCEL] || evt.rel_long[CLP_K_SET]) begin
                        menu_q <= MENU_LIVE;
                    end
                end
                MENU_EDIT: begin
                    if (evt.press[CLP_K_PLUS]) begin
                        edit_q <= plus_val;
                    end else if (evt.press[CLP_K_MINUS]) begin
                        edit_q <= minus_val;
                    end else if (evt.rel_short[CLP_K_SET]) begin
                        cursor_q <= (cursor_q == CLP_CUR_MSD) ? 2'h0 : cursor_q + 2'h1;
                    end else if (evt.rel_long[CLP_K_SET]) begin
                        menu_q <= MENU_LIVE;
                    end else if (evt.rel_short[CLP_K_CANCEL]) begin
                        menu_q <= MENU_SELECT;
                    end
                end
                default: begin
                    menu_q <= MENU_LIVE;
                end
            endcase
        end
    end

    // Stored parameters, written only by a valid long set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < 5; k++) begin
                param_q[k] <= CLP_PARAM_RST;
            end
        end else if (store) begin
            param_q[pidx] <= edit_q;
        end
    end

    // Display source: live current, item number or blinking edit value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_q <= CLP_PARAM_RST;
        end else begin
            case (menu_q)
                MENU_SELECT: disp_q <= {10'h000, item_q};
                MENU_EDIT: disp_q <= edit_q;
                default: disp_q <= cur_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // Monitor enable bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_en_q <= CLP_CTRL_MON_RST;
        end else if (psel && penable && pwrite && paddr == CLP_REG_CTRL) begin
            mon_en_q <= pwdata[CLP_CTRL_MON_BIT];
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h00000000;
        end else if (psel && !penable) begin
            rdata_q <= 32'h00000000;
            case (paddr)
                CLP_REG_CTRL: rdata_q[CLP_CTRL_MON_BIT] <= mon_en_q;
                CLP_REG_STATUS: begin
                    rdata_q[CLP_ST_RELAY] <= relay_q;
                    rdata_q[CLP_ST_VIOL] <= viol;
                    rdata_q[CLP_ST_BLANK] <= (prot_q == PROT_BLANK);
                    rdata_q[CLP_ST_LATCH] <= latched;
                    rdata_q[CLP_ST_MENU] <= (menu_q != MENU_LIVE);
                    rdata_q[CLP_ST_EDIT] <= (menu_q == MENU_EDIT);
                    rdata_q[CLP_ST_ITEM+3:CLP_ST_ITEM] <= item_q;
                end
                CLP_REG_UPPER: rdata_q[CLP_PW-1:0] <= upper_p;
                CLP_REG_LOWER: rdata_q[CLP_PW-1:0] <= lower_p;
                CLP_REG_BLANK: rdata_q[CLP_PW-1:0] <= blank_p;
                CLP_REG_CONFIRM: rdata_q[CLP_PW-1:0] <= confirm_p;
                CLP_REG_RELEASE: rdata_q[CLP_PW-1:0] <= release_p;
                CLP_REG_CURRENT: rdata_q[CLP_PW-1:0] <= cur_q;
                default: rdata_q <= 32'h00000000;
            endcase
        end
    end

    // Zero-wait answer; error on unmapped or misaligned address
    always_comb begin
        pready = 1'b1;
        pslverr = 1'b0;
        if (psel && penable) begin
            pslverr = (paddr[1:0] != 2'h0) || (paddr > CLP_REG_CURRENT);
        end
    end

    assign prdata = rdata_q;
    assign relay_on = relay_q;
    assign menu_active = (menu_q != MENU_LIVE);
    assign edit_blink = (menu_q == MENU_EDIT);
    assign menu_item = item_q;
    assign disp_value = disp_q;

endmodule : clp_protector

/* File: clp_keypad.sv */
`timescale 1ns/1ps
// --
// Operator keypad: set, plus, minus, cancel on bits 0..3
// --
module clp_keypad (
    input wire logic clk,
    output logic [3:0] keys_n
);
    // Idle keys read high through pull-ups; a press holds one low
    initial keys_n = 4'hF;
    task automatic hit(input int k, input int ticks);
        keys_n[k] <= 1'b0;
        repeat (ticks * 4) @(posedge clk);
        keys_n[k] <= 1'b1;
        repeat (120) @(posedge clk);
    endtask : hit
endmodule : clp_keypad

/* File: clp_protector_checker.sv */
`timescale 1ns/1ps
// --
// Menu checks
// --
module clp_protector_checker
    import clp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic key_set_n,
    input wire logic cancel_key_n,
    input wire logic relay_on,
    input wire logic menu_active,
    input wire logic edit_blink,
    input wire logic [3:0] menu_item
);
    // Menu mode moves only on key releases; the item steps on plus and minus presses
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_open; $rose(menu_active) |-> key_set_n && menu_item == 4'h1; endproperty
    a_open: assert property (p_open) else $error("open");
    property p_sel; $rose(menu_active) |-> !edit_blink; endproperty
    a_sel: assert property (p_sel) else $error("sel");
    property p_blk; edit_blink |-> menu_active; endproperty
    a_blk: assert property (p_blk) else $error("blink");
    property p_edit; $rose(edit_blink) |-> key_set_n && $stable(menu_item); endproperty
    a_edit: assert property (p_edit) else $error("edit");
    property p_item; $changed(menu_item) |-> menu_active && !edit_blink; endproperty
    a_item: assert property (p_item) else $error("item");
    property p_rng; menu_item inside {[4'h1:4'h9]}; endproperty
    a_rng: assert property (p_rng) else $error("range");
    property p_close; $fell(menu_active) |-> key_set_n && cancel_key_n; endproperty
    a_close: assert property (p_close) else $error("close");
    property p_drop; $fell(edit_blink) |-> key_set_n && cancel_key_n; endproperty
    a_drop: assert property (p_drop) else $error("drop");
    c_menu: cover property ($rose(menu_active));
    c_edit: cover property ($fell(edit_blink) && menu_active);
    c_trip: cover property ($rose(relay_on));
endmodule : clp_protector_checker
bind clp_protector clp_protector_checker u_chk (
    .pclk(pclk), .presetn(presetn), .key_set_n(key_set_n), .cancel_key_n(cancel_key_n),
    .relay_on(relay_on), .menu_active(menu_active), .edit_blink(edit_blink), .menu_item(menu_item)
);

/* File: clp_protector_bench.sv */
`timescale 1ns/1ps
// --
// Bench
// --
module clp_protector_bench
    import clp_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cur_valid = 1'b1, er;
    logic pready, pslverr, relay_on, menu_active, edit_blink;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [13:0] cur_value = 14'h0000, disp_value;
    logic [3:0] menu_item, keys_n;
    wire key_set_n = keys_n[0], key_plus_n = keys_n[1], key_minus_n = keys_n[2], cancel_key_n = keys_n[3];
    int errors = 0, samples_checked = 0, cycles = 0;
    clp_keypad u_pad (.clk(pclk), .keys_n(keys_n));
    clp_protector #(.TICK_DIV(4)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_set_n(key_set_n),
        .key_plus_n(key_plus_n), .key_minus_n(key_minus_n), .cancel_key_n(cancel_key_n),
        .cur_value(cur_value), .cur_valid(cur_valid), .relay_on(relay_on), .menu_active(menu_active),
        .edit_blink(edit_blink), .menu_item(menu_item), .disp_value(disp_value)
    );
    // Clock and hang guard
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %h %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask : apb
    task automatic end_of_test();
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    // Reset status and an unmapped read
    task automatic t_regs();
        apb(1'b0, CLP_REG_STATUS, 32'h0);
        chk(rd, 32'h100);
        apb(1'b0, 8'h20, 32'h0);
        chk({rd[31:1], er}, 32'h1);
    endtask : t_regs
    // Walk the menu, drop one edit, store the next
    task automatic t_menu();
        u_pad.hit(0, 320);
        chk(32'({menu_active, edit_blink, menu_item}), 32'h21);
        u_pad.hit(1, 20);
        chk(32'(menu_item), 32'h2);
        u_pad.hit(2, 20);
        chk(32'(menu_item), 32'h1);
        repeat (3) u_pad.hit(0, 20);
        u_pad.hit(1, 20);
        chk(32'({edit_blink, disp_value}), 32'h4064);
        u_pad.hit(3, 20);
        apb(1'b0, CLP_REG_UPPER, 32'h0);
        chk({rd[31:2], menu_active, edit_blink}, 32'h2);
        repeat (3) u_pad.hit(0, 20);
        u_pad.hit(1, 20);
        u_pad.hit(0, 320);
        apb(1'b0, CLP_REG_UPPER, 32'h0);
        chk({rd[31:1], menu_active}, 32'h64);
    endtask : t_menu
    // Trip above the upper limit, fall back, then mute the monitor
    task automatic t_trip();
        cur_value <= 14'h0096;
        repeat (40) @(posedge pclk);
        chk(32'({relay_on, disp_value}), 32'h4096);
        cur_value <= 14'h0032;
        repeat (40) @(posedge pclk);
        chk(32'(relay_on), 32'h0);
        apb(1'b1, CLP_REG_CTRL, 32'h0);
        cur_value <= 14'h0096;
        repeat (40) @(posedge pclk);
        chk(32'(relay_on), 32'h0);
        cur_valid <= 1'b0;
        cur_value <= 14'h0010;
        repeat (4) @(posedge pclk);
        chk(32'(disp_value), 32'h96);
        cur_valid <= 1'b1;
    endtask : t_trip
    // Store a lower limit of ten, trip below it, then release
    task automatic t_lower();
        apb(1'b1, CLP_REG_CTRL, 32'h1);
        u_pad.hit(0, 320);
        u_pad.hit(1, 20);
        repeat (2) u_pad.hit(0, 20);
        u_pad.hit(1, 20);
        u_pad.hit(0, 320);
        apb(1'b0, CLP_REG_LOWER, 32'h0);
        chk(rd, 32'hA);
        cur_value <= 14'h0005;
        repeat (40) @(posedge pclk);
        chk(32'(relay_on), 32'h1);
        cur_value <= 14'h0032;
        repeat (40) @(posedge pclk);
        chk(32'(relay_on), 32'h0);
    endtask : t_lower
    // Confirmation delay of ten ticks holds off the trip
    task automatic t_confirm();
        u_pad.hit(0, 320);
        repeat (3) u_pad.hit(1, 20);
        repeat (2) u_pad.hit(0, 20);
        u_pad.hit(1, 20);
        u_pad.hit(0, 320);
        cur_value <= 14'h0096;
        repeat (20) @(posedge pclk);
        chk(32'(relay_on), 32'h0);
        repeat (60) @(posedge pclk);
        chk(32'(relay_on), 32'h1);
    endtask : t_confirm
    // Reset for eight cycles, then run each scenario
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_menu();
        t_trip();
        t_lower();
        t_confirm();
        end_of_test();
    end
endmodule : clp_protector_bench
